// ==== core/hub_cfg_consts.svh ====
/*
 * Constants of the hub identity and power configuration register bank:
 * register offsets, field positions, reset values and the bus address.
 * Assumes it is included by bare name from the modules and the testbench.
 */
`ifndef HUB_CFG_CONSTS_SVH
`define HUB_CFG_CONSTS_SVH

// Register offsets on the two-wire configuration port.
`define OFS_PRODUCT_ID_HIGH     8'h03
`define OFS_RELEASE_LOW         8'h04
`define OFS_RELEASE_HIGH        8'h05
`define OFS_HUB_CONFIG_ONE      8'h06

// Reset values; every identity byte and config bit comes up zero.
`define RST_PRODUCT_ID_HIGH     8'h00
`define RST_RELEASE_LOW         8'h00
`define RST_RELEASE_HIGH        8'h00
`define RST_HUB_CONFIG_ONE      8'h00

// Field positions inside configuration byte one.
`define POS_POWER_SOURCE        7
`define POS_RESERVED_SIX        6
`define POS_FULL_SPEED_ONLY     5
`define POS_PER_PORT_TT         4

// Mask of bits that software may store in configuration byte one.
`define MASK_HUB_CONFIG_ONE     8'hBF

// Seven-bit bus address of the slave; the value is arbitrary.
`define SLAVE_ADDRESS           7'h40

// Bit counter marks: last data bit, ack bit, end of ack.
`define CNT_LAST_BIT            4'h7
`define CNT_ACK_BIT             4'h8
`define CNT_ACK_DONE            4'h9

// Value returned for offsets this bank does not hold.
`define READ_UNMAPPED           8'h00

`endif

// ==== core/hub_cfg_pkg.sv ====
/*
 * Types shared by the configuration register bank and its helpers.
 * Assumes the constants header is on the include path.
 */
package hub_cfg_pkg;

   // Phases of the two-wire slave engine.
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,  // Not addressed; waits for a start.
      ST_ADDR  = 3'b001,  // Shifting in the address byte.
      ST_CMD   = 3'b010,  // Shifting in the register offset.
      ST_WDATA = 3'b011,  // Shifting in write data.
      ST_RDATA = 3'b100   // Shifting out read data.
   } slave_state_e;

   // Whole state of the register bank and slave engine.
   typedef struct packed {
      slave_state_e st;      // Engine phase.
      logic [3:0]   cnt;     // Bit position within the byte.
      logic [7:0]   sh;      // Shift register.
      logic [7:0]   ptr;     // Current register offset.
      logic         oe;      // Pulling the data line low.
      logic         out;     // Data line output level.
      logic [7:0]   pid_hi;  // Product identifier, upper byte.
      logic [7:0]   rel_lo;  // Release number, low byte.
      logic [7:0]   rel_hi;  // Release number, high byte.
      logic [7:0]   hub_config_byte_one;    // Configuration byte one.
   } bank_s;

   // Previous levels of the two bus lines.
   typedef struct packed {
      logic scl;  // Clock line one cycle ago.
      logic sda;  // Data line one cycle ago.
   } line_s;

   // Resolved operating mode of the hub.
   typedef struct packed {
      logic self_pwr;  // Hub runs as self-powered.
      logic lps;       // Local power source status bit.
      logic fs_only;   // Attach as full-speed only.
      logic mtt;       // Per-port translators in use.
   } mode_s;

endpackage

// ==== core/hub_identity_and_power_config_regs.sv ====
/*
 * Identity and power configuration register bank of a two-port hub,
 * reached through its two-wire configuration slave port. Holds the
 * product identifier upper byte, the release number and configuration
 * byte one, and drives the resolved operating modes to attach logic.
 * Assumes the clock and data lines are synchronous to clk, and that the
 * data line is an open-drain wire resolved outside from sda_oe.
 */
`include "hub_cfg_consts.svh"

module hub_identity_and_power_config_regs (
   input  wire logic        clk,          // System clock, 40 MHz.
   input  wire logic        rst,          // Async reset, active high.
   input  wire logic        scl_in,       // Config port clock line.
   input  wire logic        sda_in,       // Config port data line in.
   output logic             sda_out,      // Data line drive level.
   output logic             sda_oe,       // High while pulling low.
   input  wire logic        dynamic_power_enable,   // Auto switching.
   input  wire logic        local_supply_sense_pin, // Local supply.
   input  wire logic        shared_translator_mode, // Host chose one TT.
   output logic [7:0]       product_id_high_byte,   // PID upper byte.
   output logic [15:0]      release_number,         // BCD release.
   output logic             self_powered,       // Runs self-powered.
   output logic             local_power_status, // Hub status bit 0.
   output logic             full_speed_only,    // No high speed.
   output logic             per_port_translator_active // Multi-TT.
);

   hub_cfg_pkg::bank_s s_q;  // Registered state of the bank.
   hub_cfg_pkg::bank_s s_d;  // Next state of the bank.

   logic scl_rise;  // Clock line rising edge.
   logic scl_fall;  // Clock line falling edge.
   logic start_ev;  // Start or repeated start.
   logic stop_ev;   // Stop condition.

   logic [7:0] rd_byte;  // Register value at the pointer.

   // Line conditions come from the shared edge detector.
   smbus_line_events u_events (
      .clk      (clk),
      .rst      (rst),
      .scl_in   (scl_in),
      .sda_in   (sda_in),
      .scl_rise (scl_rise),
      .scl_fall (scl_fall),
      .start_ev (start_ev),
      .stop_ev  (stop_ev)
   );

   // Read multiplexer over the offsets this bank holds.
   // Other offsets read as zero so a master probing the wider map
   // sees a defined value rather than stale bus data.
   always_comb begin
      unique case (s_q.ptr)
         `OFS_PRODUCT_ID_HIGH: begin
            rd_byte = s_q.pid_hi;
         end
         `OFS_RELEASE_LOW: begin
            rd_byte = s_q.rel_lo;
         end
         `OFS_RELEASE_HIGH: begin
            rd_byte = s_q.rel_hi;
         end
         `OFS_HUB_CONFIG_ONE: begin
            // The reserved bit is never stored, so it reads zero.
            rd_byte = s_q.hub_config_byte_one & `MASK_HUB_CONFIG_ONE;
         end
         default: begin
            rd_byte = `READ_UNMAPPED;
         end
      endcase
   end

   // Slave engine and register writes. Data is sampled on the clock
   // rising edge and driven after the falling edge, so the line only
   // changes while the clock is low and never fakes a start or stop.
   always_comb begin
      s_d     = s_q;
      s_d.out = 1'b0;
      if (start_ev) begin
         // A start, repeated or not, always restarts address capture.
         s_d.st  = hub_cfg_pkg::ST_ADDR;
         s_d.cnt = 4'h0;
         s_d.oe  = 1'b0;
      end else if (stop_ev) begin
         // A stop ends any transfer and frees the line.
         s_d.st  = hub_cfg_pkg::ST_IDLE;
         s_d.cnt = 4'h0;
         s_d.oe  = 1'b0;
      end else begin
         unique case (s_q.st)
            hub_cfg_pkg::ST_IDLE: begin
               // Not addressed; the line stays released.
               s_d.oe = 1'b0;
            end
            hub_cfg_pkg::ST_ADDR,
            hub_cfg_pkg::ST_CMD,
            hub_cfg_pkg::ST_WDATA: begin
               if (scl_rise && s_q.cnt < `CNT_ACK_BIT) begin
                  // Most significant bit arrives first.
                  s_d.sh  = {s_q.sh[6:0], sda_in};
                  s_d.cnt = s_q.cnt + 4'h1;
               end else if (scl_fall && s_q.cnt == `CNT_ACK_BIT) begin
                  // Whole byte in; act on it and drive the ack.
                  s_d.cnt = `CNT_ACK_DONE;
                  s_d.oe  = 1'b1;
                  if (s_q.st == hub_cfg_pkg::ST_ADDR) begin
                     if (s_q.sh[7:1] != `SLAVE_ADDRESS) begin
                        // Another slave is addressed; stay silent.
                        s_d.st = hub_cfg_pkg::ST_IDLE;
                        s_d.oe = 1'b0;
                     end
                  end else if (s_q.st == hub_cfg_pkg::ST_CMD) begin
                     s_d.ptr = s_q.sh;
                  end else begin
                     // Write to the addressed byte, then advance.
                     unique case (s_q.ptr)
                        `OFS_PRODUCT_ID_HIGH: begin
                           s_d.pid_hi = s_q.sh;
                        end
                        `OFS_RELEASE_LOW: begin
                           s_d.rel_lo = s_q.sh;
                        end
                        `OFS_RELEASE_HIGH: begin
                           s_d.rel_hi = s_q.sh;
                        end
                        `OFS_HUB_CONFIG_ONE: begin
                           // Bit 6 is dropped on the way in.
                           s_d.hub_config_byte_one = s_q.sh
                                    & `MASK_HUB_CONFIG_ONE;
                        end
                        default: begin
                           // Unheld offsets accept and discard data.
                           s_d.ptr = s_q.ptr;
                        end
                     endcase
                     s_d.ptr = s_q.ptr + 8'h01;
                  end
               end else if (scl_fall && s_q.cnt == `CNT_ACK_DONE) begin
                  // Ack bit over; release and pick the next phase.
                  s_d.cnt = 4'h0;
                  s_d.oe  = 1'b0;
                  if (s_q.st == hub_cfg_pkg::ST_ADDR) begin
                     if (s_q.sh[0]) begin
                        // Read: first data bit goes out at once.
                        s_d.st  = hub_cfg_pkg::ST_RDATA;
                        s_d.sh  = rd_byte;
                        s_d.oe  = ~rd_byte[7];
                        s_d.ptr = s_q.ptr + 8'h01;
                     end else begin
                        s_d.st = hub_cfg_pkg::ST_CMD;
                     end
                  end else begin
                     s_d.st = hub_cfg_pkg::ST_WDATA;
                  end
               end
            end
            hub_cfg_pkg::ST_RDATA: begin
               if (scl_fall && s_q.cnt < `CNT_LAST_BIT) begin
                  // Present the next bit while the clock is low.
                  s_d.sh  = {s_q.sh[6:0], 1'b0};
                  s_d.cnt = s_q.cnt + 4'h1;
                  s_d.oe  = ~s_q.sh[6];
               end else if (scl_fall && s_q.cnt == `CNT_LAST_BIT) begin
                  // Free the line so the master can ack or nack.
                  s_d.cnt = `CNT_ACK_BIT;
                  s_d.oe  = 1'b0;
               end else if (scl_rise && s_q.cnt == `CNT_ACK_BIT) begin
                  if (sda_in) begin
                     // Nack ends the read; wait for stop or start.
                     s_d.st = hub_cfg_pkg::ST_IDLE;
                  end else begin
                     s_d.cnt = `CNT_ACK_DONE;
                  end
               end else if (scl_fall && s_q.cnt == `CNT_ACK_DONE) begin
                  // Ack seen; stream the next byte.
                  s_d.cnt = 4'h0;
                  s_d.sh  = rd_byte;
                  s_d.oe  = ~rd_byte[7];
                  s_d.ptr = s_q.ptr + 8'h01;
               end
            end
            default: begin
               // Illegal code: recover to idle with the line free.
               s_d.st = hub_cfg_pkg::ST_IDLE;
               s_d.oe = 1'b0;
            end
         endcase
      end
   end

   // All bank state resets to zero, so with dynamic switching off the hub comes up bus-powered,
   // high-speed capable, with one shared translator. The hub should
   // stay detached until the master has loaded the bank.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q        <= '0;
         s_q.st     <= hub_cfg_pkg::ST_IDLE;
         s_q.pid_hi <= `RST_PRODUCT_ID_HIGH;
         s_q.rel_lo <= `RST_RELEASE_LOW;
         s_q.rel_hi <= `RST_RELEASE_HIGH;
         s_q.hub_config_byte_one   <= `RST_HUB_CONFIG_ONE;
      end else begin
         s_q <= s_d;
      end
   end

   // Mode resolution lives apart so attach logic sees one clean view.
   hub_power_mode_resolver u_modes (
      .clk                        (clk),
      .rst                        (rst),
      .power_source_select        (s_q.hub_config_byte_one[`POS_POWER_SOURCE]),
      .full_speed_only_select     (s_q.hub_config_byte_one[`POS_FULL_SPEED_ONLY]),
      .per_port_translator_enable (s_q.hub_config_byte_one[`POS_PER_PORT_TT]),
      .dynamic_power_enable       (dynamic_power_enable),
      .local_supply_sense_pin     (local_supply_sense_pin),
      .shared_translator_mode     (shared_translator_mode),
      .self_powered               (self_powered),
      .local_power_status         (local_power_status),
      .full_speed_only            (full_speed_only),
      .per_port_active            (per_port_translator_active)
   );

   // Bank outputs are the registers themselves.
   assign sda_out              = s_q.out;
   assign sda_oe               = s_q.oe;
   assign product_id_high_byte = s_q.pid_hi;
   assign release_number       = {s_q.rel_hi, s_q.rel_lo};

endmodule

// ==== core/hub_power_mode_resolver.sv ====
/*
 * Resolves the hub's power, speed and translator modes from the stored
 * configuration and the live pins. Assumes all inputs share clk.
 */
`include "hub_cfg_consts.svh"

module hub_power_mode_resolver (
   input  wire logic clk,             // System clock.
   input  wire logic rst,             // Asynchronous reset, active high.
   input  wire logic power_source_select,         // Stored power bit.
   input  wire logic full_speed_only_select,      // Stored speed bit.
   input  wire logic per_port_translator_enable,  // Stored TT bit.
   input  wire logic dynamic_power_enable,        // Auto power switching.
   input  wire logic local_supply_sense_pin,      // Local supply level.
   input  wire logic shared_translator_mode,      // Host chose one TT.
   output logic      self_powered,    // Operating self-powered.
   output logic      local_power_status,  // Status bit zero to host.
   output logic      full_speed_only, // Attach full-speed only.
   output logic      per_port_active  // Per-port translators active.
);

   hub_cfg_pkg::mode_s m_q;  // Registered mode.
   hub_cfg_pkg::mode_s m_d;  // Next mode.

   // Decide each mode bit every cycle from its sources.
   always_comb begin
      m_d = m_q;
      if (dynamic_power_enable) begin
         // The stored bit is ignored; the sense pin decides.
         m_d.self_pwr = local_supply_sense_pin;
         m_d.lps      = local_supply_sense_pin;
      end else begin
         m_d.self_pwr = power_source_select;
         m_d.lps      = ~power_source_select;
      end
      m_d.fs_only = full_speed_only_select;
      // Host selection of one translator overrides per-port mode.
      m_d.mtt = per_port_translator_enable
              & ~shared_translator_mode;
   end

   // Registered so every mode output comes straight from a flop.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         m_q <= '0;
      end else begin
         m_q <= m_d;
      end
   end

   assign self_powered       = m_q.self_pwr;
   assign local_power_status = m_q.lps;
   assign full_speed_only    = m_q.fs_only;
   assign per_port_active    = m_q.mtt;

endmodule

// ==== core/smbus_line_events.sv ====
/*
 * Edge and condition detector for the clock and data lines of the
 * configuration port. Assumes both lines are synchronous to clk.
 */
`include "hub_cfg_consts.svh"

module smbus_line_events (
   input  wire logic clk,       // System clock.
   input  wire logic rst,       // Asynchronous reset, active high.
   input  wire logic scl_in,    // Clock line level.
   input  wire logic sda_in,    // Data line level.
   output logic      scl_rise,  // Clock line rose this cycle.
   output logic      scl_fall,  // Clock line fell this cycle.
   output logic      start_ev,  // Start or repeated start seen.
   output logic      stop_ev    // Stop condition seen.
);

   hub_cfg_pkg::line_s s_q;  // Registered line levels.
   hub_cfg_pkg::line_s s_d;  // Next line levels.

   // Capture the present levels for edge comparison.
   always_comb begin
      s_d.scl = scl_in;
      s_d.sda = sda_in;
   end

   // Lines idle high, so reset to that level to avoid a false edge.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= '1;
      end else begin
         s_q <= s_d;
      end
   end

   // Data moving while the clock stays high marks start or stop.
   assign scl_rise = scl_in & ~s_q.scl;
   assign scl_fall = ~scl_in & s_q.scl;
   assign start_ev = scl_in & s_q.scl & s_q.sda & ~sda_in;
   assign stop_ev  = scl_in & s_q.scl & ~s_q.sda & sda_in;

endmodule

// ==== testbench/hub_cfg_host_model.sv ====
/*
 * Configuration host model: a two-wire bus master bit-banging the clock
 * and data lines. Assumes the data line is resolved outside with a
 * pull-up and that the hub samples both lines on clk.
 */
module hub_cfg_host_model (
   input  wire logic       clk,       // System clock.
   input  wire logic       sda,       // Resolved data line.
   output logic            scl,       // Clock line from the host.
   output logic            sda_m,     // Host data drive, 1 releases.
   output logic            rd_pulse,  // One cycle per byte read.
   output logic [7:0]      rd_data    // Byte just read.
);
   timeunit 1ns;
   timeprecision 1ps;
   // Lines idle high from time zero, so reset never sees a start.
   initial begin
      scl      = 1'b1;
      sda_m    = 1'b1;
      rd_pulse = 1'b0;
      rd_data  = 8'h00;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Start or repeated start: data falls while the clock stays high.
   task automatic start();
      sda_m <= 1'b1;
      tick(2);
      scl <= 1'b1;
      tick(2);
      sda_m <= 1'b0;
      tick(2);
      scl <= 1'b0;
      tick(2);
   endtask
   // Stop: data rises while the clock is high.
   task automatic stop();
      sda_m <= 1'b0;
      tick(2);
      scl <= 1'b1;
      tick(2);
      sda_m <= 1'b1;
      tick(2);
   endtask
   // One bit; the line is read mid-high, away from any hub update.
   task automatic bit_cycle(input logic b, output logic s);
      sda_m <= b;
      tick(2);
      scl <= 1'b1;
      tick(2);
      #1 s = sda;
      tick(1);
      scl <= 1'b0;
      tick(2);
   endtask
   // Byte out, most significant bit first; ack is the line pulled low.
   task automatic send(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_cycle(b[i], s);
      bit_cycle(1'b1, s);
      ack = ~s;
   endtask
   // Byte in; the last byte is refused so the hub lets go of the line.
   task automatic recv(input logic last, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_cycle(1'b1, s);
         b[i] = s;
      end
      bit_cycle(last, s);
      rd_data  <= b;
      rd_pulse <= 1'b1;
      tick(1);
      rd_pulse <= 1'b0;
   endtask
endmodule

// ==== testbench/hub_cfg_regs_properties.sv ====
/*
 * Checker of the hub configuration bank, watching its ports only.
 * Assumes one clock domain and an asynchronous active-high reset.
 */
module hub_cfg_regs_properties (
   input  wire logic        clk,  // System clock.
   input  wire logic        rst,  // Asynchronous reset.
   input  wire logic        scl_in,                 // Clock line.
   input  wire logic        sda_oe,                 // Data pull.
   input  wire logic        dynamic_power_enable,   // Auto switching.
   input  wire logic        local_supply_sense_pin, // Supply pin.
   input  wire logic        shared_translator_mode, // One TT.
   input  wire logic [7:0]  product_id_high_byte,   // Product byte.
   input  wire logic [15:0] release_number,         // Release.
   input  wire logic        self_powered,           // Self power.
   input  wire logic        local_power_status,     // Status bit.
   input  wire logic        full_speed_only,        // No high speed.
   input  wire logic        per_port_translator_active // Multi-TT.
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // Nothing has been written yet when reset lets go.
   a_reset_zero: assert property ($fell(rst) |->
      product_id_high_byte == 8'h00 && release_number == 16'h0000 &&
      !self_powered && !full_speed_only && !per_port_translator_active)
      else $error("identity or mode not zero after reset");
   a_status_inverse: assert property (
      !$past(dynamic_power_enable) && !$past(rst) |->
      local_power_status == !self_powered)
      else $error("status bit is not inverse of power mode");
   a_dyn_sense: assert property (
      $past(dynamic_power_enable) && !$past(rst) |->
      self_powered == $past(local_supply_sense_pin) &&
      local_power_status == $past(local_supply_sense_pin))
      else $error("dynamic power does not follow sense pin");
   a_shared_tt: assert property (
      $past(shared_translator_mode) |-> !per_port_translator_active)
      else $error("per-port translators kept under host choice");
   // Stored bytes change only as a data byte is acknowledged.
   a_pid_write: assert property (
      $changed(product_id_high_byte) |-> $rose(sda_oe) && !scl_in)
      else $error("product byte changed outside a write");
   a_rel_write: assert property (
      $changed(release_number) |-> $rose(sda_oe) && !scl_in)
      else $error("release number changed outside a write");
   a_ack_timing: assert property ($rose(sda_oe) |->
      !scl_in && !$past(scl_in) && ($past(scl_in, 2) || $past(scl_in, 3)))
      else $error("data line pulled outside the clock low phase");
   a_fs_write: assert property (
      $changed(full_speed_only) |-> $past(sda_oe) && !$past(sda_oe, 2))
      else $error("speed mode changed without a register write");
   a_ppt_rise: assert property (
      $rose(per_port_translator_active) |->
      !$past(shared_translator_mode) && ($past(shared_translator_mode, 2)
      || ($past(sda_oe) && !$past(sda_oe, 2))))
      else $error("per-port translators rose without a cause");
   c_ack: cover property ($rose(sda_oe));
   c_multi_tt: cover property ($rose(per_port_translator_active));
   c_dyn_self: cover property (dynamic_power_enable && self_powered);
endmodule

bind hub_identity_and_power_config_regs hub_cfg_regs_properties
   hub_cfg_regs_properties_i (.clk, .rst, .scl_in, .sda_oe,
   .dynamic_power_enable, .local_supply_sense_pin, .shared_translator_mode,
   .product_id_high_byte, .release_number, .self_powered,
   .local_power_status, .full_speed_only, .per_port_translator_active);

// ==== testbench/hub_identity_and_power_config_regs_test.sv ====
/*
 * Self-checking bench of the hub configuration bank, driven through the
 * host model. Assumes the constants header is on the include path.
 */
`include "hub_cfg_consts.svh"
module hub_identity_and_power_config_regs_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst, scl, sda_m, sda_in, sda_out, sda_oe; // Bus.
   logic        dyn, pin, one_tt;          // Mode inputs.
   logic [7:0]  pid;                       // Product byte.
   logic [15:0] rel;                       // Release number.
   logic        selfp, lps, fso, ppt;      // Resolved modes.
   logic        rd_pulse;                  // Host read a byte.
   logic [7:0]  rd_data;                   // That byte.
   logic [7:0]  exp_q[$];                  // Expected read bytes.
   int          bad_count;                 // Mismatches.
   int          check_count;               // Comparisons.
   // Open-drain data line with pull-up: low when either side pulls.
   assign sda_in = sda_m & ~sda_oe;
   hub_identity_and_power_config_regs hub_identity_and_power_config_regs_i (
      .clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda_in),
      .sda_out(sda_out), .sda_oe(sda_oe), .dynamic_power_enable(dyn),
      .local_supply_sense_pin(pin), .shared_translator_mode(one_tt),
      .product_id_high_byte(pid), .release_number(rel),
      .self_powered(selfp), .local_power_status(lps),
      .full_speed_only(fso), .per_port_translator_active(ppt));
   hub_cfg_host_model hub_cfg_host_model_i (.clk(clk), .sda(sda_in),
      .scl(scl), .sda_m(sda_m), .rd_pulse(rd_pulse), .rd_data(rd_data));
   initial clk = 1'b0;
   always #12.5 clk = ~clk;
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks=%0d mismatches=%0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // A hang anywhere counts as a failure.
   initial begin
      repeat (40000) @(posedge clk);
      bad_count++;
      print_verdict();
   end
   // Every byte the host reads is matched against the oldest note.
   always @(posedge clk) begin
      if (rd_pulse === 1'b1) begin
         if (exp_q.size() == 0) begin
            check(16'(rd_data), 16'hFFFF);
         end else begin
            check(16'(rd_data), 16'(exp_q.pop_front()));
         end
      end
   end
   // Start, our address for writing, then the register offset.
   task automatic head(input logic [7:0] ofs);
      logic a;
      @(posedge clk);
      hub_cfg_host_model_i.start();
      hub_cfg_host_model_i.send({`SLAVE_ADDRESS, 1'b0}, a);
      check(16'(a), 16'h1);
      hub_cfg_host_model_i.send(ofs, a);
      check(16'(a), 16'h1);
   endtask
   task automatic wr(input logic [7:0] ofs, input logic [7:0] d[$]);
      logic a;
      head(ofs);
      foreach (d[i]) begin
         hub_cfg_host_model_i.send(d[i], a);
         check(16'(a), 16'h1);
      end
      hub_cfg_host_model_i.stop();
   endtask
   task automatic rd(input logic [7:0] ofs, input int n);
      logic a;
      logic [7:0] b;
      head(ofs);
      hub_cfg_host_model_i.start();
      hub_cfg_host_model_i.send({`SLAVE_ADDRESS, 1'b1}, a);
      check(16'(a), 16'h1);
      for (int i = 0; i < n; i++) hub_cfg_host_model_i.recv(i == n - 1, b);
      hub_cfg_host_model_i.stop();
   endtask
   initial begin
      logic [7:0] v;
      logic       a;
      logic       p;
      rst = 1'b1;
      dyn = 1'b0;
      pin = 1'b0;
      one_tt = 1'b0;
      v = 8'($urandom(32'hB493));
      v = 8'($urandom());
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(negedge clk);
      check(16'(pid), 16'h0000);
      check(rel, 16'h0000);
      check(16'({selfp, lps, fso, ppt}), 16'h4);
      // The whole bank is programmed before attach would happen.
      wr(`OFS_PRODUCT_ID_HIGH, '{v, 8'h34, 8'h12, 8'hF0});
      @(negedge clk);
      check(16'(pid), 16'(v));
      check(rel, 16'h1234);
      check(16'({selfp, lps, fso, ppt}), 16'hB);
      // Read the burst back and run one offset past the bank.
      exp_q = '{v, 8'h34, 8'h12, 8'hB0, `READ_UNMAPPED};
      rd(`OFS_PRODUCT_ID_HIGH, 5);
      // The host's single-translator choice wins over per-port mode.
      @(posedge clk);
      one_tt <= 1'b1;
      repeat (2) @(posedge clk);
      @(negedge clk);
      check(16'(ppt), 16'h0);
      @(posedge clk);
      one_tt <= 1'b0;
      dyn <= 1'b1;
      // With dynamic switching the sense pin decides both outputs.
      for (int i = 0; i < 8; i++) begin
         p = 1'($urandom());
         @(posedge clk);
         pin <= p;
         @(posedge clk);
         @(negedge clk);
         check(16'({selfp, lps}), {14'h0, p, p});
      end
      @(posedge clk);
      dyn <= 1'b0;
      // A foreign address is left unacknowledged.
      hub_cfg_host_model_i.start();
      hub_cfg_host_model_i.send({`SLAVE_ADDRESS ^ 7'h01, 1'b0}, a);
      check(16'(a), 16'h0);
      hub_cfg_host_model_i.stop();
      // Only the reserved bit is written: it is dropped, modes clear.
      wr(`OFS_HUB_CONFIG_ONE, '{8'h40});
      exp_q.push_back(8'h00);
      rd(`OFS_HUB_CONFIG_ONE, 1);
      @(negedge clk);
      check(16'({selfp, lps, fso, ppt}), 16'h4);
      check(16'(sda_out), 16'h0);
      print_verdict();
   end
endmodule
